// ### logic/tsr_filter.sv
// Purpose: Synchronise and width-qualify one external input
// Assumes: Raw pin is asynchronous to the core clock
// Notes: Output changes only after the level is stable for the width
`timescale 1ns/10ps
module tsr_filter
	import tsr_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_pin,
	input wire logic i_long,
	output logic o_level
);
	logic s1_q, s2_q, lvl_q, lvl_d;
	logic [FW-1:0] cnt_q, cnt_d;
	logic [FW-1:0] lim;
	always_comb
	begin
		lim = i_long ? FW'(W_LONG_CYC - 1) : FW'(W_SHORT_CYC - 1);
		lvl_d = lvl_q;
		cnt_d = '0;
		// Short pulses never reach the output
		if (s2_q != lvl_q)
		begin
			cnt_d = cnt_q + 1'b1;
			if (cnt_q >= lim)
			begin
				lvl_d = s2_q;
				cnt_d = '0;
			end
		end
	end
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			lvl_q <= 1'b0;
			cnt_q <= '0;
		end
		else
		begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			lvl_q <= lvl_d;
			cnt_q <= cnt_d;
		end
	end
	assign o_level = lvl_q;
	chk_pulse_reject: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(s2_q != lvl_q) && cnt_q == '0 ##1 (s2_q == lvl_q) |-> ##1 $stable(lvl_q))
		else $error("short pulse passed filter");
endmodule : tsr_filter

// ### logic/tsr_pkg.sv
// Purpose: Shared constants and types for the timer setpoint/reset/backup block
// Assumes: 125 MHz core clock, AHB-Lite register access
// Notes: Times are kept in their own unit, cycle counts derived
package tsr_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_MHZ = 125;
	localparam int W_SHORT_US = 1000;
	localparam int W_LONG_US = 20000;
	localparam int RST_SHORT_MIN_US = 800;
	localparam int RST_SHORT_MAX_US = 1200;
	localparam int RST_LONG_MIN_US = 15000;
	localparam int RST_LONG_MAX_US = 25000;
	localparam int TICK_US = 1000;
	localparam int W_SHORT_CYC = W_SHORT_US * CLK_MHZ;
	localparam int W_LONG_CYC = W_LONG_US * CLK_MHZ;
	localparam int TICK_CYC = TICK_US * CLK_MHZ;
	localparam int NV_BUDGET = 100000;
	localparam int CNT_W = 24;
	localparam int FW = 22;
	// ****************************************
	// Register map (byte offsets)
	// ****************************************
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_SET1 = 8'h04;
	localparam logic [7:0] A_SET2 = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	localparam logic [7:0] A_PV = 8'h10;
	localparam logic [7:0] A_NVCNT = 8'h14;
	// CTRL fields
	localparam int C_FUNC = 0;
	localparam int C_DOWN = 2;
	localparam int C_WIDTH = 3;
	localparam int C_MODE = 4;
	localparam int C_RUN = 8;
	localparam logic [3:0] M_RETAIN = 4'h3;
	localparam logic [3:0] M_CUMUL = 4'h8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	typedef enum logic [1:0] {FN_SINGLE, FN_TWIN, FN_TWO_STAGE, FN_RSV} tsr_func_t;
	typedef enum {ST_IDLE, ST_TIMING, ST_UP2, ST_DONE} tsr_state_t;
	typedef struct packed {
		logic start;
		logic rst;
		logic gate;
	} tsr_in_t;
endpackage : tsr_pkg

// ### logic/tsr_top.sv
// Purpose: Timer control around set value compare, reset and backup
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes: Counts in 1 ms ticks; nonvolatile write is a request strobe
`timescale 1ns/10ps
module tsr_top
	import tsr_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic i_start,
	input wire logic i_rst_in,
	input wire logic i_gate,
	input wire logic i_power_fail,
	output logic o_out1,
	output logic o_out2,
	output logic o_nv_write,
	output logic o_nv_exhausted
);
	// ****************************************
	// Input qualification
	// ****************************************
	logic [31:0] ctrl_q, ctrl_d;
	tsr_in_t raw, qin;
	assign raw = '{start: i_start, rst: i_rst_in, gate: i_gate};
	logic [2:0] raw_v, q_v;
	assign raw_v = raw;
	assign qin = q_v;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_flt
			tsr_filter u_flt (
				.i_core_clk(i_core_clk),
				.i_reset(i_reset),
				.i_pin(raw_v[gi]),
				.i_long(~ctrl_q[C_WIDTH]),
				.o_level(q_v[gi])
			);
		end
	endgenerate
	// ****************************************
	// AHB-Lite slave
	// ****************************************
	logic wr_q, wr_d, rd_q, rd_d;
	logic [7:0] adr_q, adr_d;
	logic [31:0] rdata_q, rdata_d;
	logic [CNT_W-1:0] set1_q, set1_d, set2_q, set2_d;
	logic [CNT_W-1:0] pv_q, pv_d;
	logic [16:0] nvc_q, nvc_d;
	logic nvw_q, nvw_d, pf_s1_q, pf_s2_q, pf_q, exh_q;
	logic out1_q, out1_d, out2_q, out2_d;
	tsr_state_t st_q, st_d;
	logic [16:0] tick_q, tick_d;
	logic set_chg;
	logic [CNT_W-1:0] new_set;
	always_comb
	begin
		wr_d = 1'b0;
		rd_d = 1'b0;
		adr_d = adr_q;
		if (i_hsel && i_hready && i_htrans[1])
		begin
			wr_d = i_hwrite;
			rd_d = ~i_hwrite;
			adr_d = i_haddr[7:0];
		end
		rdata_d = 32'h0000_0000;
		if (rd_d)
		begin
			case (i_haddr[7:0])
				A_CTRL: rdata_d = ctrl_q;
				A_SET1: rdata_d = {8'h00, set1_q};
				A_SET2: rdata_d = {8'h00, set2_q};
				A_STAT: rdata_d = {28'h0000000, out2_q, out1_q,
					st_q == ST_DONE, st_q != ST_IDLE};
				A_PV: rdata_d = {8'h00, pv_q};
				A_NVCNT: rdata_d = {15'h0000, nvc_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end
	always_comb
	begin
		ctrl_d = ctrl_q;
		set1_d = set1_q;
		set2_d = set2_q;
		set_chg = 1'b0;
		new_set = i_hwdata[CNT_W-1:0];
		if (wr_q)
		begin
			case (adr_q)
				A_CTRL:
				begin
					ctrl_d = i_hwdata;
					set_chg = 1'b1;
				end
				A_SET1:
				begin
					set1_d = new_set;
					set_chg = 1'b1;
				end
				A_SET2:
				begin
					set2_d = new_set;
					set_chg = 1'b1;
				end
				default: set_chg = 1'b0;
			endcase
		end
	end
	// ****************************************
	// Nonvolatile backup control
	// ****************************************
	logic mode_pwr;
	assign mode_pwr = ctrl_q[C_MODE+:4] == M_RETAIN ||
		ctrl_q[C_MODE+:4] == M_CUMUL;
	always_comb
	begin
		nvw_d = 1'b0;
		nvc_d = nvc_q;
		if (nvc_q < 17'(NV_BUDGET))
		begin
			if (mode_pwr)
				nvw_d = pf_q & ~pf_s2_q ? 1'b0 : (pf_s2_q & ~pf_q);
			else
				nvw_d = set_chg;
		end
		if (nvw_d)
			nvc_d = nvc_q + 1'b1;
	end
	// ****************************************
	// Timing core
	// ****************************************
	logic tick, rst_edge_q, pv_reach;
	logic [CNT_W-1:0] act_set, elapsed;
	tsr_func_t fn;
	assign fn = tsr_func_t'(ctrl_q[C_FUNC+:2]);
	assign tick = tick_q == 17'(TICK_CYC - 1);
	assign act_set = (st_q == ST_UP2) ? set2_q : set1_q;
	assign elapsed = act_set - pv_q;
	always_comb
	begin
		tick_d = tick ? 17'h00000 : tick_q + 1'b1;
		st_d = st_q;
		pv_d = pv_q;
		out1_d = out1_q;
		out2_d = out2_q;
		pv_reach = 1'b0;
		case (st_q)
			ST_IDLE:
				if (ctrl_q[C_RUN] && qin.start)
				begin
					st_d = ST_TIMING;
					pv_d = ctrl_q[C_DOWN] ? set1_q : '0;
					out1_d = fn == FN_TWIN ? 1'b0 : out1_q;
				end
			ST_TIMING, ST_UP2:
			begin
				if (tick && !qin.gate)
					pv_d = ctrl_q[C_DOWN] ? (pv_q == '0 ? pv_q : pv_q - 1'b1)
						: pv_q + 1'b1;
				if (ctrl_q[C_DOWN])
				begin
					if (wr_q && adr_q == A_SET1 && st_q == ST_TIMING)
					begin
						if (new_set <= elapsed)
							pv_d = '0;
						else
							pv_d = pv_q + new_set - set1_q;
					end
					pv_reach = pv_d == '0;
				end
				else
					pv_reach = pv_d >= act_set;
				if (pv_reach)
				begin
					case (fn)
						FN_TWIN:
						begin
							out1_d = ~out1_q;
							pv_d = ctrl_q[C_DOWN] ? set1_q : '0;
						end
						FN_TWO_STAGE:
							if (st_q == ST_TIMING)
							begin
								out1_d = 1'b1;
								st_d = ST_UP2;
							end
							else
							begin
								out2_d = 1'b1;
								st_d = ST_DONE;
							end
						default:
						begin
							out1_d = 1'b1;
							st_d = ST_DONE;
						end
					endcase
				end
			end
			ST_DONE: st_d = ST_DONE;
			default: st_d = ST_IDLE;
		endcase
		if (qin.rst)
		begin
			st_d = ST_IDLE;
			out1_d = 1'b0;
			out2_d = 1'b0;
			pv_d = '0;
		end
	end
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			adr_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
			ctrl_q <= CTRL_RST;
			set1_q <= '0;
			set2_q <= '0;
			nvw_q <= 1'b0;
			nvc_q <= '0;
			exh_q <= 1'b0;
			pf_s1_q <= 1'b0;
			pf_s2_q <= 1'b0;
			pf_q <= 1'b0;
			st_q <= ST_IDLE;
			pv_q <= '0;
			tick_q <= '0;
			out1_q <= 1'b0;
			out2_q <= 1'b0;
			rst_edge_q <= 1'b0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			adr_q <= adr_d;
			rdata_q <= rdata_d;
			ctrl_q <= ctrl_d;
			set1_q <= set1_d;
			set2_q <= set2_d;
			nvw_q <= nvw_d;
			nvc_q <= nvc_d;
			exh_q <= nvc_d >= 17'(NV_BUDGET);
			pf_s1_q <= i_power_fail;
			pf_s2_q <= pf_s1_q;
			pf_q <= pf_s2_q;
			st_q <= st_d;
			pv_q <= pv_d;
			tick_q <= tick_d;
			out1_q <= out1_d;
			out2_q <= out2_d;
			rst_edge_q <= qin.rst;
		end
	end
	assign o_hrdata = rdata_q;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_out1 = out1_q;
	assign o_out2 = out2_q;
	assign o_nv_write = nvw_q;
	assign o_nv_exhausted = exh_q;
	// ****************************************
	// Checks
	// ****************************************
	sequence s_rst_rise;
		qin.rst && !rst_edge_q;
	endsequence
	chk_reset_clears: assert property (@(posedge i_core_clk)
		disable iff (i_reset) s_rst_rise |-> ##1 (!out1_q && !out2_q))
		else $error("output not cleared after reset");
	chk_nv_on_change: assert property (@(posedge i_core_clk)
		disable iff (i_reset) set_chg && !mode_pwr && nvc_q < 17'(NV_BUDGET)
		|-> ##1 nvw_q) else $error("no backup on change");
	chk_nv_pwr_only: assert property (@(posedge i_core_clk)
		disable iff (i_reset) mode_pwr && !(pf_s2_q && !pf_q) |-> ##1 !nvw_q)
		else $error("backup outside power off");
	chk_nv_budget: assert property (@(posedge i_core_clk)
		disable iff (i_reset) nvc_q >= 17'(NV_BUDGET) |-> ##1 !nvw_q)
		else $error("write past budget");
	chk_up_reach: assert property (@(posedge i_core_clk)
		disable iff (i_reset) st_q == ST_TIMING && !ctrl_q[C_DOWN] &&
		fn == FN_SINGLE && pv_q >= set1_q && !qin.rst |-> ##1 out1_q)
		else $error("up compare missed");
	chk_down_zero: assert property (@(posedge i_core_clk)
		disable iff (i_reset) st_q == ST_TIMING && ctrl_q[C_DOWN] && wr_q &&
		adr_q == A_SET1 && new_set <= elapsed && fn == FN_SINGLE && !qin.rst
		|-> ##1 (pv_q == '0 && out1_q)) else $error("down set not zeroed");
	chk_down_adjust: assert property (@(posedge i_core_clk)
		disable iff (i_reset) st_q == ST_TIMING && ctrl_q[C_DOWN] && wr_q &&
		adr_q == A_SET1 && new_set > elapsed && !tick && !qin.rst
		&& fn == FN_SINGLE |-> ##1 pv_q == $past(pv_q) + $past(new_set) - $past(set1_q))
		else $error("down adjust wrong");
	chk_two_stage: assert property (@(posedge i_core_clk)
		disable iff (i_reset) st_q == ST_DONE && fn == FN_TWO_STAGE |-> out2_q)
		else $error("two-stage end without out2");
endmodule : tsr_top

// ### sim/tb.sv
// Purpose: Self-checking bench for the timer control block
// Assumes: Zero-wait AHB slave, 1 ms input width used
// Notes: Width counts are fixed, so the run is long
`timescale 1ns/10ps
module tb;
	import tsr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hrdy;
	logic hresp;
	logic pin_s, pin_r, pin_g;
	logic pfail = 1'b0;
	logic out1, out2, nvw, nvx;
	int n_mismatch = 0;
	int n_tests = 0;
	int nv_seen = 0;
	int seed = 32'he9f72b0f;
	always #4 clk = ~clk;
	always @(posedge clk)
		if (nvw === 1'b1)
			nv_seen <= nv_seen + 1;
	tsr_pins tsr_pins_inst (.i_core_clk(clk), .o_start(pin_s),
		.o_rst(pin_r), .o_gate(pin_g));
	tsr_top tsr_top_inst (.i_core_clk(clk), .i_reset(rst), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
		.o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
		.i_start(pin_s), .i_rst_in(pin_r), .i_gate(pin_g),
		.i_power_fail(pfail), .o_out1(out1), .o_out2(out2),
		.o_nv_write(nvw), .o_nv_exhausted(nvx));
	// ****************************************
	// Checks and bus tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : ahb
	function automatic logic [31:0] ctrl(input int fn, input bit dn,
		input logic [3:0] md);
		return 32'h108 | fn | (dn << C_DOWN) | (md << C_MODE);
	endfunction : ctrl
	function automatic int nv_exp(input logic [3:0] md);
		return (md == M_RETAIN || md == M_CUMUL) ? 0 : 1;
	endfunction : nv_exp
	task automatic wait_timing;
		logic [31:0] r;
		int n;
		n = 0;
		do
		begin
			repeat (100) @(posedge clk);
			ahb(1'b0, A_STAT, 32'h0, r);
			n++;
		end
		while (r[0] !== 1'b1 && n < 1400);
		chk(r[0], 1'b1);
	endtask : wait_timing
	initial
	begin
		repeat (2200000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		logic [31:0] r, p0;
		logic [3:0] md;
		int b, n;
		logic [3:0] modes [4];
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		ahb(1'b0, A_CTRL, 32'h0, r);
		chk(r, CTRL_RST);
		ahb(1'b0, 8'h40, 32'h0, r);
		chk(r, 32'h0);
		for (int f = 0; f < 3; f++)
		begin
			ahb(1'b1, A_CTRL, f, r);
			ahb(1'b0, A_CTRL, 32'h0, r);
			chk(r[1:0], f[1:0]);
		end
		modes = '{4'h0, M_RETAIN, M_CUMUL, 4'h5};
		foreach (modes[i])
		begin
			md = modes[i];
			ahb(1'b1, A_CTRL, ctrl(0, 0, md) & 32'hFF, r);
			repeat (4) @(posedge clk);
			b = nv_seen;
			ahb(1'b1, A_SET2, $random(seed) & 32'hFFFFFF, r);
			repeat (4) @(posedge clk);
			chk(nv_seen - b, nv_exp(md));
			pfail <= 1'b1;
			repeat (8) @(posedge clk);
			chk(nv_seen - b, 1);
			pfail <= 1'b0;
			repeat (8) @(posedge clk);
		end
		ahb(1'b0, A_NVCNT, 32'h0, r);
		chk(r, nv_seen);
		chk(nvx, 1'b0);
		ahb(1'b1, A_SET1, 32'd1000, r);
		ahb(1'b1, A_CTRL, ctrl(0, 0, 4'h0), r);
		tsr_pins_inst.pulse(1'b0, W_SHORT_CYC / 2);
		repeat (W_SHORT_CYC) @(posedge clk);
		ahb(1'b0, A_STAT, 32'h0, r);
		chk(r[0], 1'b0);
		tsr_pins_inst.pulse(1'b0, W_SHORT_CYC + 5000);
		wait_timing();
		repeat (2 * TICK_CYC + 20) @(posedge clk);
		ahb(1'b1, A_SET1, 32'd1, r);
		repeat (4) @(posedge clk);
		chk(out1, 1'b1);
		n = 0;
		fork
			tsr_pins_inst.pulse(1'b1, W_SHORT_CYC + 5000);
			while (out1 === 1'b1 && n < 160000)
			begin
				@(posedge clk);
				n++;
			end
		join
		chk(n >= RST_SHORT_MIN_US * CLK_MHZ, 1'b1);
		chk(n <= RST_SHORT_MAX_US * CLK_MHZ, 1'b1);
		chk(out1, 1'b0);
		ahb(1'b1, A_SET1, 32'd10, r);
		ahb(1'b1, A_CTRL, ctrl(0, 1, 4'h0), r);
		tsr_pins_inst.pulse(1'b0, W_SHORT_CYC + 5000);
		wait_timing();
		repeat (3 * TICK_CYC) @(posedge clk);
		ahb(1'b0, A_PV, 32'h0, p0);
		ahb(1'b1, A_SET1, 32'd12, r);
		ahb(1'b0, A_PV, 32'h0, r);
		chk(r, p0 + 2);
		ahb(1'b1, A_SET1, 32'd2, r);
		repeat (4) @(posedge clk);
		chk(out1, 1'b1);
		ahb(1'b0, A_PV, 32'h0, r);
		chk(r, 32'h0);
		chk(out2, 1'b0);
		chk(hresp, 1'b0);
		print_verdict();
	end
endmodule : tb

// ### sim/tsr_pins.sv
// Purpose: Model of the external start, reset and gate devices
// Assumes: Pins change right after a rising edge
// Notes: Gate stays low, so counting never pauses
`timescale 1ns/10ps
module tsr_pins
(
	input wire logic i_core_clk,
	output logic o_start,
	output logic o_rst,
	output logic o_gate
);
	initial
	begin
		o_start = 1'b0;
		o_rst = 1'b0;
		o_gate = 1'b0;
	end
	// Holds one pin high for cyc cycles
	task automatic pulse(input bit rst, input int cyc);
		@(posedge i_core_clk);
		o_rst <= rst;
		o_start <= !rst;
		repeat (cyc) @(posedge i_core_clk);
		o_rst <= 1'b0;
		o_start <= 1'b0;
	endtask : pulse
endmodule : tsr_pins
